// ### bench/cpe_counters_test.sv
`timescale 1ns/100ps
module cpe_counters_test;
	import cpe_pkg::*;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hreadyout, hresp, irq, strobe;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [6:0] evt;
	logic [CV_W-1:0] lat_cv;
	logic [7:0] lat_rx, lat_gen;
	int bad_count = 0;
	int checks_done = 0;
	// ------------------------------------------------
	// Event bits: code, excess, crc, rx inc/dec, gen inc/dec
	// ------------------------------------------------
	localparam logic [6:0] E_CV = 7'h01, E_EZ = 7'h02, E_CRC = 7'h04, E_RI = 7'h08;
	localparam logic [6:0] E_RD = 7'h10, E_GI = 7'h20, E_GD = 7'h40;

	cpe_counters u_cpe_counters (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.code_viol_evt(evt[0]), .excess_zero_evt(evt[1]), .line_checksum_mode_err_evt(evt[2]),
		.rx_ptr_inc_evt(evt[3]), .rx_ptr_dec_evt(evt[4]), .gen_ptr_inc_evt(evt[5]),
		.gen_ptr_dec_evt(evt[6]), .one_second_strobe_in(strobe),
		.latched_code_viol_count(lat_cv), .latched_rx_ptr_counts(lat_rx),
		.latched_gen_ptr_counts(lat_gen), .irq(irq)
	);

	always #4 hclk = ~hclk;

	// ------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------
	task automatic give_verdict();
		if (bad_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'b010;
		haddr <= {22'h0, idx, 2'b00};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		xfer(idx, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] d);
		xfer(idx, 1'b0, 32'h0);
		d = rv;
	endtask

	// Event pulses, one count per high cycle, back to back
	task automatic ev(input logic [6:0] v, input int n);
		repeat (n) begin
			@(posedge hclk);
			evt <= v;
		end
		@(posedge hclk);
		evt <= 7'h00;
	endtask

	initial begin
		repeat (5000) @(posedge hclk);
		bad_count++;
		give_verdict();
	end

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		haddr = 32'h0;
		hwdata = 32'h0;
		evt = 7'h00;
		strobe = 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd(IDX_CTRL, rv); chk(rv, 32'h0);
		rd(IDX_MASK, rv); chk(rv, 32'h0);
		rd(IDX_FLAGS, rv); chk(rv, 32'h0);
		wr(IDX_CTRL, 32'h05);
		ev(E_CV, 3);
		ev(E_CV | E_EZ, 1);
		rd(IDX_CV_LOW, rv); chk(rv, 32'h05);
		wr(IDX_CV_LOW, 32'hff);
		wr(IDX_CV_HIGH, 32'h0f);
		rd(IDX_CV_HIGH, rv); chk(rv, 32'h0f);
		ev(E_CV, 1);
		rd(IDX_CV_LOW, rv); chk(rv, 32'h00);
		rd(IDX_CV_HIGH, rv); chk(rv, 32'h00);
		rd(IDX_FLAGS, rv); chk(rv, 32'h009);
		wr(IDX_LINE_CFG, 32'h10);
		ev(E_CV, 2);
		ev(E_CRC, 3);
		rd(IDX_CV_LOW, rv); chk(rv, 32'h03);
		wr(IDX_LINE_CFG, 32'h00);
		wr(IDX_CV_LOW, 32'h00);
		rd(IDX_CV_LOW, rv); chk(rv, 32'h00);
		ev(E_RI, 3);
		ev(E_RD, 2);
		ev(E_GI, 1);
		ev(E_GD, 4);
		rd(IDX_RX_PTR, rv); chk(rv, 32'h32);
		rd(IDX_GEN_PTR, rv); chk(rv, 32'h14);
		wr(IDX_CTRL, 32'h00);
		ev(E_GI, 2);
		ev(E_GD, 1);
		rd(IDX_GEN_PTR, rv); chk(rv, 32'h15);
		ev(E_RI, 13);
		ev(E_GD, 11);
		rd(IDX_RX_PTR, rv); chk(rv, 32'h02);
		rd(IDX_GEN_PTR, rv); chk(rv, 32'h10);
		rd(IDX_FLAGS, rv); chk(rv, 32'h03f);
		chk({31'h0, irq}, 32'h0);
		wr(IDX_MASK, 32'h002);
		repeat (3) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		wr(IDX_FLAGS, 32'h03f);
		repeat (3) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		rd(IDX_FLAGS, rv); chk(rv, 32'h000);
		wr(IDX_RX_PTR, 32'h00);
		rd(IDX_RX_PTR, rv); chk(rv, 32'h00);
		// Monitoring on, one second boundary
		wr(IDX_CTRL, 32'h06);
		wr(IDX_GEN_PTR, 32'h00);
		ev(E_CV, 3);
		ev(E_RI, 2);
		ev(E_RD, 1);
		ev(E_GI, 4);
		ev(E_GD, 5);
		@(posedge hclk);
		strobe <= 1'b1;
		repeat (6) @(posedge hclk);
		strobe <= 1'b0;
		chk({20'h0, lat_cv}, 32'h003);
		chk({24'h0, lat_rx}, 32'h21);
		chk({24'h0, lat_gen}, 32'h45);
		rd(IDX_CV_LOW, rv); chk(rv, 32'h00);
		rd(IDX_RX_PTR, rv); chk(rv, 32'h00);
		rd(IDX_GEN_PTR, rv); chk(rv, 32'h00);
		ev(E_RI, 16);
		rd(IDX_FLAGS, rv); chk(rv, 32'h492);
		chk({31'h0, irq}, 32'h1);
		chk({31'h0, hresp}, 32'h0);
		rd(8'h3f, rv); chk(rv, 32'h0);
		// Mid-run reset returns state to idle
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		chk({31'h0, irq}, 32'h0);
		chk({20'h0, lat_cv}, 32'h000);
		chk({24'h0, lat_rx}, 32'h00);
		rd(IDX_FLAGS, rv); chk(rv, 32'h000);
		rd(IDX_CTRL, rv); chk(rv, 32'h00);
		give_verdict();
	end
endmodule // cpe_counters_test

// ### logic/cpe_counters.sv
`timescale 1ns/100ps
// Function
// R1 - Line violation counter is twelve bits; upper nibble in bits 3-0.
// R2 - With excess-zero enable, excess-zero events also count as violations.
// R3 - Line counter overflow sets status, event; monitor bits when enabled.
// R4 - Monitoring on: each second copy line counter to shadow, clear it.
// R5 - Checksum mode counts CRC-6 errors instead, byte-synchronous modes only.
// R6 - Software writes zeros to reserved bits 7-4 of the upper register.
// R7 - Bits 7-4 count received pointer increments.
// R8 - Bits 3-0 count received pointer decrements.
// R9 - Received pointer overflow sets status, event; monitor bits when enabled.
// R10 - Bits 7-4 count generated increments in byte-synchronous mode.
// R11 - Bits 3-0 count generated pointer decrements.
// R12 - Generated pointer overflow sets status, event; monitor bits when enabled.
// R13 - Writing zero clears a counter; counting restarts from zero.
// R14 - Monitoring on: each second latch pointer counters to shadow, clear them.
// R15 - The one-second interval comes from the external strobe input.
// R16 - Lower byte lives in the preceding register; both form one counter.
// R17 - Counters wrap to zero on overflow while flags are raised.
// R18 - A write or the second latch wins over a coincident increment.
module cpe_counters (
	input wire logic hclk, // Bus clock
	input wire logic hresetn, // Async reset, low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic [2:0] hsize, // Size, word only
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	output logic [31:0] hrdata, // Read data
	input wire logic code_viol_evt, // Line code violation
	input wire logic excess_zero_evt, // Excess zeros seen
	input wire logic line_checksum_mode_err_evt, // CRC-6 error
	input wire logic rx_ptr_inc_evt, // Received increment
	input wire logic rx_ptr_dec_evt, // Received decrement
	input wire logic gen_ptr_inc_evt, // Generated increment
	input wire logic gen_ptr_dec_evt, // Generated decrement
	input wire logic one_second_strobe_in, // External 1 s pin
	output logic [cpe_pkg::CV_W-1:0] latched_code_viol_count, // Shadow
	output logic [7:0] latched_rx_ptr_counts, // Shadow
	output logic [7:0] latched_gen_ptr_counts, // Shadow
	output logic irq // Level interrupt
);
	import cpe_pkg::*;

	function automatic logic [NIB_W:0] cpe_bump(input logic [NIB_W-1:0] v, input logic e);
		return {1'b0, v} + {{NIB_W{1'b0}}, e};
	endfunction

	//----------------------------------------
	// Bus slave
	//----------------------------------------
	logic ph_r;
	logic wr_r;
	logic map_r;
	logic [7:0] idx_r;
	logic hreadyout_r;
	logic [31:0] hrdata_r;
	logic hresp_r;
	wire take = hsel && htrans[TRANS_ACTIVE_BIT] && hready;
	wire wr_en = ph_r && wr_r && map_r;
	wire [31:0] wdata = hwdata;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_r <= 1'b0;
			wr_r <= 1'b0;
			map_r <= 1'b0;
			idx_r <= 8'h00;
		end else begin
			ph_r <= take;
			if (take) begin
				wr_r <= hwrite;
				map_r <= (haddr[31:IDX_MSB+1] == '0);
				idx_r <= haddr[IDX_MSB:IDX_LSB];
			end
		end
	end

	//----------------------------------------
	// Control registers
	//----------------------------------------
	logic [7:0] ctrl_r;
	logic checksum_r;
	logic [FLAG_W-1:0] mask_r;
	wire ezc_en = ctrl_r[CTRL_EZC_BIT];
	wire pm_en = ctrl_r[CTRL_PM_BIT];
	wire bsync = ctrl_r[CTRL_BSYNC_BIT];
	wire wr_ctrl = wr_en && idx_r == IDX_CTRL;
	wire wr_cfg = wr_en && idx_r == IDX_LINE_CFG;
	wire wr_mask = wr_en && idx_r == IDX_MASK;
	wire wr_flags = wr_en && idx_r == IDX_FLAGS;
	wire wr_cvl = wr_en && idx_r == IDX_CV_LOW;
	wire wr_cvh = wr_en && idx_r == IDX_CV_HIGH;
	wire wr_rx = wr_en && idx_r == IDX_RX_PTR;
	wire wr_gen = wr_en && idx_r == IDX_GEN_PTR;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= CTRL_RST;
			checksum_r <= 1'b0;
			mask_r <= MASK_RST;
		end else begin
			if (wr_ctrl)
				ctrl_r <= wdata[7:0];
			if (wr_cfg)
				checksum_r <= wdata[CFG_CHECKSUM_BIT];
			if (wr_mask)
				mask_r <= wdata[FLAG_W-1:0];
		end
	end

	//----------------------------------------
	// One-second strobe
	//----------------------------------------
	logic sec_s1_r;
	logic sec_s2_r;
	logic sec_s3_r;
	wire sec_tick = sec_s2_r && !sec_s3_r; // [R15]
	wire sec_clr = sec_tick && pm_en;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_s1_r <= 1'b0;
			sec_s2_r <= 1'b0;
			sec_s3_r <= 1'b0;
		end else begin
			sec_s1_r <= one_second_strobe_in;
			sec_s2_r <= sec_s1_r;
			sec_s3_r <= sec_s2_r;
		end
	end

	//----------------------------------------
	// Line violation counter
	//----------------------------------------
	logic [CV_W-1:0] cv_cnt_r;
	wire csel = checksum_r && bsync; // [R5]
	wire [1:0] cv_viol = {1'b0, code_viol_evt} + {1'b0, ezc_en && excess_zero_evt}; // [R2]
	wire [1:0] cv_inc = csel ? {1'b0, line_checksum_mode_err_evt} : cv_viol; // [R1] [R5]
	wire [CV_W:0] cv_sum = {1'b0, cv_cnt_r} + {{(CV_W-1){1'b0}}, cv_inc}; // [R17]
	wire cv_wr = wr_cvl || wr_cvh;
	// Writes load the written field; reserved bits are dropped
	wire [CV_W-1:0] cv_nxt = wr_cvl ? {cv_cnt_r[CV_W-1:CV_LOW_W], wdata[CV_LOW_W-1:0]} : // [R16]
		wr_cvh ? {wdata[CV_W-CV_LOW_W-1:0], cv_cnt_r[CV_LOW_W-1:0]} : // [R13] [R6]
		sec_clr ? '0 : cv_sum[CV_W-1:0]; // [R4] [R18]
	wire cv_ovf = !cv_wr && !sec_clr && cv_sum[CV_W]; // [R3]

	//----------------------------------------
	// Pointer counters
	//----------------------------------------
	logic [NIB_W-1:0] rx_inc_r;
	logic [NIB_W-1:0] rx_dec_r;
	logic [NIB_W-1:0] gen_inc_r;
	logic [NIB_W-1:0] gen_dec_r;
	wire [NIB_W:0] rx_inc_b = cpe_bump(rx_inc_r, rx_ptr_inc_evt); // [R7]
	wire [NIB_W:0] rx_dec_b = cpe_bump(rx_dec_r, rx_ptr_dec_evt); // [R8]
	wire [NIB_W:0] gen_inc_b = cpe_bump(gen_inc_r, gen_ptr_inc_evt && bsync); // [R10]
	wire [NIB_W:0] gen_dec_b = cpe_bump(gen_dec_r, gen_ptr_dec_evt); // [R11]
	wire rx_keep = !wr_rx && !sec_clr; // [R18]
	wire gen_keep = !wr_gen && !sec_clr; // [R18]
	wire rx_ovf = rx_keep && (rx_inc_b[NIB_W] || rx_dec_b[NIB_W]); // [R9]
	wire gen_ovf = gen_keep && (gen_inc_b[NIB_W] || gen_dec_b[NIB_W]); // [R12]
	wire [NIB_W-1:0] rx_inc_nxt = wr_rx ? wdata[INC_LSB+:NIB_W] : // [R13]
		sec_clr ? '0 : rx_inc_b[NIB_W-1:0]; // [R14] [R17]
	wire [NIB_W-1:0] rx_dec_nxt = wr_rx ? wdata[DEC_LSB+:NIB_W] :
		sec_clr ? '0 : rx_dec_b[NIB_W-1:0];
	wire [NIB_W-1:0] gen_inc_nxt = wr_gen ? wdata[INC_LSB+:NIB_W] : // [R13]
		sec_clr ? '0 : gen_inc_b[NIB_W-1:0]; // [R14] [R17]
	wire [NIB_W-1:0] gen_dec_nxt = wr_gen ? wdata[DEC_LSB+:NIB_W] :
		sec_clr ? '0 : gen_dec_b[NIB_W-1:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cv_cnt_r <= '0;
			rx_inc_r <= '0;
			rx_dec_r <= '0;
			gen_inc_r <= '0;
			gen_dec_r <= '0;
		end else begin
			cv_cnt_r <= cv_nxt;
			rx_inc_r <= rx_inc_nxt;
			rx_dec_r <= rx_dec_nxt;
			gen_inc_r <= gen_inc_nxt;
			gen_dec_r <= gen_dec_nxt;
		end
	end

	//----------------------------------------
	// Shadow registers
	//----------------------------------------
	logic [CV_W-1:0] lat_cv_r;
	logic [7:0] lat_rx_r;
	logic [7:0] lat_gen_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lat_cv_r <= '0;
			lat_rx_r <= 8'h00;
			lat_gen_r <= 8'h00;
		end else if (sec_clr) begin
			lat_cv_r <= cv_cnt_r; // [R4]
			lat_rx_r <= {rx_inc_r, rx_dec_r}; // [R14]
			lat_gen_r <= {gen_inc_r, gen_dec_r}; // [R14]
		end
	end

	//----------------------------------------
	// Flags and interrupt
	//----------------------------------------
	logic [FLAG_W-1:0] flags_r;
	logic irq_r;
	wire [SRC_N-1:0] ovf = {gen_ovf, rx_ovf, cv_ovf};
	wire [SRC_N-1:0] ovf_pm = ovf & {SRC_N{pm_en}};
	// Set wins over a coincident write-one clear
	wire [FLAG_W-1:0] flag_set = {ovf_pm, ovf_pm, ovf, ovf}; // [R3] [R9] [R12]
	wire [FLAG_W-1:0] flag_clr = wr_flags ? wdata[FLAG_W-1:0] : '0;
	wire [FLAG_W-1:0] flags_nxt = (flags_r & ~flag_clr) | flag_set;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_r <= '0;
			irq_r <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			irq_r <= |(flags_r & mask_r);
		end
	end

	//----------------------------------------
	// Read data and response
	//----------------------------------------
	wire [31:0] rd_val = !map_r ? 32'h0000_0000 :
		idx_r == IDX_CV_LOW ? {24'h00_0000, cv_cnt_r[CV_LOW_W-1:0]} :
		idx_r == IDX_CV_HIGH ? {28'h000_0000, cv_cnt_r[CV_W-1:CV_LOW_W]} :
		idx_r == IDX_RX_PTR ? {24'h00_0000, rx_inc_r, rx_dec_r} :
		idx_r == IDX_GEN_PTR ? {24'h00_0000, gen_inc_r, gen_dec_r} :
		idx_r == IDX_CTRL ? {24'h00_0000, ctrl_r} :
		idx_r == IDX_LINE_CFG ? 32'(checksum_r) << CFG_CHECKSUM_BIT :
		idx_r == IDX_FLAGS ? {20'h0_0000, flags_r} :
		idx_r == IDX_MASK ? {20'h0_0000, mask_r} : 32'h0000_0000;

	// One wait state so read data leaves a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_r <= 1'b1;
			hrdata_r <= 32'h0000_0000;
			hresp_r <= 1'b0;
		end else begin
			hreadyout_r <= !take;
			if (ph_r && !wr_r)
				hrdata_r <= rd_val;
		end
	end

	assign hreadyout = hreadyout_r;
	assign hrdata = hrdata_r;
	assign hresp = hresp_r;
	assign irq = irq_r;
	assign latched_code_viol_count = lat_cv_r;
	assign latched_rx_ptr_counts = lat_rx_r;
	assign latched_gen_ptr_counts = lat_gen_r;

	//----------------------------------------
	// Checks
	//----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_CV_INC: assert property ( // [R1]
		code_viol_evt && !ezc_en && !csel && !cv_wr && !sec_clr && cv_cnt_r != 12'hfff
		|=> cv_cnt_r == 12'($past(cv_cnt_r) + 12'h001))
		else $error("line counter did not step by one");
	AST_EZC_ADD: assert property ( // [R2]
		code_viol_evt && excess_zero_evt && ezc_en && !csel && !cv_wr && !sec_clr
		&& cv_cnt_r < 12'hffe |=> cv_cnt_r == 12'($past(cv_cnt_r) + 12'h002))
		else $error("excess zeros not added");
	AST_CV_OVF: assert property ( // [R3]
		cv_ovf |=> flags_r[GRP_STATUS] && flags_r[GRP_EVENT]
		&& (flags_r[GRP_MON] == $past(pm_en) || $past(flags_r[GRP_MON])))
		else $error("line overflow flags missing");
	AST_CV_LATCH: assert property ( // [R4]
		sec_clr && !cv_wr |=> lat_cv_r == $past(cv_cnt_r) && cv_cnt_r == '0)
		else $error("line counter not latched and cleared");
	AST_CRC_MODE: assert property ( // [R5]
		csel && !line_checksum_mode_err_evt && !cv_wr && !sec_clr |=> $stable(cv_cnt_r))
		else $error("checksum mode counted violations");
	AST_RX_COUNT: assert property ( // [R7]
		rx_ptr_inc_evt && rx_keep |=> rx_inc_r == 4'($past(rx_inc_r) + 4'h1))
		else $error("received increment not counted");
	AST_RX_DEC: assert property ( // [R8]
		!rx_ptr_dec_evt && rx_keep |=> rx_dec_r == $past(rx_dec_r))
		else $error("received decrement changed with no event");
	AST_RX_OVF: assert property ( // [R9]
		rx_ptr_dec_evt && rx_dec_r == 4'hf && rx_keep
		|=> rx_dec_r == 4'h0 && flags_r[GRP_STATUS+1] && flags_r[GRP_EVENT+1])
		else $error("received pointer overflow not flagged");
	AST_GEN_INC: assert property ( // [R10]
		gen_ptr_inc_evt && !bsync && gen_keep |=> $stable(gen_inc_r))
		else $error("generated increment counted outside byte-sync");
	AST_GEN_OVF: assert property ( // [R12]
		gen_ptr_dec_evt && gen_dec_r == 4'hf && gen_keep |=> flags_r[GRP_STATUS+2]) // [R11]
		else $error("generated pointer overflow not flagged");
	AST_WR_CLEAR: assert property ( // [R13]
		wr_gen && wdata[7:0] == 8'h00 |=> gen_inc_r == 4'h0 && gen_dec_r == 4'h0)
		else $error("zero write did not clear");
	AST_SEC_PTR: assert property ( // [R14]
		sec_clr && !wr_rx |=> lat_rx_r == {$past(rx_inc_r), $past(rx_dec_r)} && rx_inc_r == '0)
		else $error("pointer counters not latched");
	AST_IRQ: assert property (
		|(flags_r & mask_r) |=> irq)
		else $error("interrupt not raised");
	AST_WAIT: assert property (
		take |=> !hreadyout ##1 hreadyout)
		else $error("wait state wrong");
	AST_READY_IDLE: assert property (
		!take |=> hreadyout)
		else $error("wait state without a transfer");
	AST_CV_FAULT: assert property ( // [R3]
		cv_ovf && pm_en |=> flags_r[GRP_MON] && flags_r[GRP_FAULT])
		else $error("line overflow monitor flags missing");
	AST_CV_WRAP: assert property ( // [R17]
		cv_inc == 2'b01 && cv_cnt_r == 12'hfff && !cv_wr && !sec_clr |=> cv_cnt_r == '0)
		else $error("line counter did not wrap");
	AST_CV_HIGH_WR: assert property ( // [R13]
		wr_cvh |=> cv_cnt_r[CV_W-1:CV_LOW_W] == $past(wdata[CV_W-CV_LOW_W-1:0]))
		else $error("upper nibble write not loaded");
	AST_CV_LOW_WR: assert property ( // [R16]
		wr_cvl |=> cv_cnt_r[CV_W-1:CV_LOW_W] == $past(cv_cnt_r[CV_W-1:CV_LOW_W]))
		else $error("low byte write disturbed upper nibble");
	AST_CV_WR_WINS: assert property ( // [R18]
		wr_cvl && cv_inc != 2'b00 |=> cv_cnt_r[CV_LOW_W-1:0] == $past(wdata[CV_LOW_W-1:0]))
		else $error("event beat a counter write");
	AST_RX_PM: assert property ( // [R9]
		rx_ovf && pm_en |=> flags_r[GRP_MON+1] && flags_r[GRP_FAULT+1])
		else $error("received pointer monitor flags missing");
	AST_RX_PM_OFF: assert property ( // [R9]
		rx_ovf && !pm_en && !wr_flags |=> flags_r[GRP_FAULT+1] == $past(flags_r[GRP_FAULT+1]))
		else $error("fault monitor flag set with monitoring off");
	AST_GEN_DEC: assert property ( // [R11]
		gen_ptr_dec_evt && gen_keep |=> gen_dec_r == 4'($past(gen_dec_r) + 4'h1))
		else $error("generated decrement not counted");
	AST_GEN_PM: assert property ( // [R12]
		gen_ovf && pm_en |=> flags_r[GRP_MON+2] && flags_r[GRP_FAULT+2])
		else $error("generated pointer monitor flags missing");
	AST_SEC_GEN: assert property ( // [R14]
		sec_clr && !wr_gen |=> lat_gen_r == {$past(gen_inc_r), $past(gen_dec_r)} && gen_dec_r == '0)
		else $error("generated counters not latched");
	AST_FLAG_SET_WINS: assert property (
		wr_flags && |flag_set |=> (flags_r & $past(flag_set)) == $past(flag_set))
		else $error("flag clear beat a coincident set");

endmodule // cpe_counters

// ### logic/cpe_pkg.sv
package cpe_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_LINE_CFG = 8'h01;
	localparam logic [7:0] IDX_CV_LOW = 8'h22;
	localparam logic [7:0] IDX_CV_HIGH = 8'h23;
	localparam logic [7:0] IDX_RX_PTR = 8'h24;
	localparam logic [7:0] IDX_GEN_PTR = 8'h25;
	localparam logic [7:0] IDX_CTRL = 8'h30;
	localparam logic [7:0] IDX_FLAGS = 8'h31;
	localparam logic [7:0] IDX_MASK = 8'h32;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned IDX_MSB = 9;
	// Field positions
	localparam int unsigned CFG_CHECKSUM_BIT = 4;
	localparam int unsigned CTRL_EZC_BIT = 0;
	localparam int unsigned CTRL_PM_BIT = 1;
	localparam int unsigned CTRL_BSYNC_BIT = 2;
	localparam int unsigned NIB_W = 4;
	localparam int unsigned INC_LSB = 4;
	localparam int unsigned DEC_LSB = 0;
	localparam int unsigned CV_W = 12;
	localparam int unsigned CV_LOW_W = 8;
	localparam int unsigned SRC_N = 3;
	localparam int unsigned FLAG_W = 12;
	localparam int unsigned GRP_STATUS = 0;
	localparam int unsigned GRP_EVENT = 3;
	localparam int unsigned GRP_MON = 6;
	localparam int unsigned GRP_FAULT = 9;
	localparam int unsigned TRANS_ACTIVE_BIT = 1;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [FLAG_W-1:0] MASK_RST = 12'h000;
endpackage
